/* File: tofd_pkg.sv */
// Package: constants for the timer overflow and frequency divider block.
// Assumes a single 25 MHz clock and a plain register port.
package tofd_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [3:0] TOFD_ADDR_T0CTL = 4'h0;
   localparam logic [3:0] TOFD_ADDR_T0CNT = 4'h1;
   localparam logic [3:0] TOFD_ADDR_T1CTL = 4'h2;
   localparam logic [3:0] TOFD_ADDR_T1CNTL = 4'h3;
   localparam logic [3:0] TOFD_ADDR_T1CNTH = 4'h4;
   localparam logic [3:0] TOFD_ADDR_INTC = 4'h5;
   localparam logic [3:0] TOFD_ADDR_PORT = 4'h6;
   localparam logic [3:0] TOFD_ADDR_STAT = 4'h7;
   // ----------------------------------------
   // Control fields
   // ----------------------------------------
   localparam int TOFD_MODE_HI = 7;
   localparam int TOFD_MODE_LO = 6;
   localparam int TOFD_EN_BIT = 4;
   localparam int TOFD_EDGE_BIT = 3;
   localparam int TOFD_PSC_HI = 2;
   localparam int TOFD_PSC_LO = 0;
   localparam logic [1:0] TOFD_MODE_EVENT = 2'h1;
   localparam logic [1:0] TOFD_MODE_TIMER = 2'h2;
   localparam logic [1:0] TOFD_MODE_PWM = 2'h3;
   // Interrupt control, port and status bits
   localparam int TOFD_INTC_T0EN = 1;
   localparam int TOFD_INTC_T1EN = 2;
   localparam int TOFD_INTC_T0F = 5;
   localparam int TOFD_INTC_T1F = 6;
   localparam int TOFD_PORT_PDDIR = 0;
   localparam int TOFD_PORT_PDDAT = 1;
   localparam int TOFD_PORT_PBDIR = 2;
   localparam int TOFD_PORT_PDOUT = 3;
   localparam int TOFD_PORT_PDN = 4;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] TOFD_RST_CTL = 8'h00;
   localparam logic [7:0] TOFD_RST_INTC = 8'h00;
   localparam logic [7:0] TOFD_RST_PORT = 8'h01;
   localparam logic [6:0] TOFD_RST_PSC = 7'h00;
endpackage : tofd_pkg

/* File: tofd_cnt_if.sv */
// Interface: one timer's control and status toward its counter.
// Assumes the parent drives control and reads status.
`timescale 1ns/1ns
interface tofd_cnt_if;
   logic [7:0] ctl;
   logic wr_cnt;
   logic [15:0] wr_val;
   logic hold;
   logic tick;
   logic pin;
   logic [15:0] cnt;
   logic ovf;
   logic en_clr;
   modport ctrl (output ctl, output wr_cnt, output wr_val, output hold, output tick, output pin,
      input cnt, input ovf, input en_clr);
   modport core (input ctl, input wr_cnt, input wr_val, input hold, input tick, input pin,
      output cnt, output ovf, output en_clr);
endinterface : tofd_cnt_if

/* File: tofd_counter.sv */
// Counter core: one up counter with preload, overflow and mode handling.
// Assumes tick is a prescaled one-cycle enable and pin is synchronous.
`timescale 1ns/1ns
module tofd_counter
   import tofd_pkg::*;
#(
   parameter int W = 8
)
(
   input wire logic clk,
   input wire logic rst,
   tofd_cnt_if.core cif
);
   logic [W-1:0] preload;
   logic [W-1:0] cnt;
   logic pin_q;
   logic active;
   logic [W-1:0] next_preload;
   logic [W-1:0] next_cnt;
   logic next_pin_q;
   logic next_active;
   logic ovf;
   logic en_clr;
   logic [1:0] mode;
   logic edge_sel;
   logic run;
   logic rise;
   logic fall;
   logic inc;

   assign mode = cif.ctl[TOFD_MODE_HI:TOFD_MODE_LO];
   assign edge_sel = cif.ctl[TOFD_EDGE_BIT];
   assign run = cif.ctl[TOFD_EN_BIT];
   assign rise = cif.pin & ~pin_q;
   assign fall = ~cif.pin & pin_q;
   assign cif.cnt = 16'(cnt);
   assign cif.ovf = ovf;
   assign cif.en_clr = en_clr;

   always_comb
   begin
      next_preload = preload;
      next_cnt = cnt;
      next_pin_q = pin_q;
      next_active = active;
      ovf = 1'b0;
      en_clr = 1'b0;
      inc = 1'b0;
      if (cif.wr_cnt)
      begin
         next_preload = cif.wr_val[W-1:0];
         next_cnt = cif.wr_val[W-1:0];
      end
      // R11: pin sampled on tick
      if (cif.tick)
      begin
         next_pin_q = cif.pin;
      end
      // R12: clock held on access
      if (!cif.hold && cif.tick && run && !cif.wr_cnt)
      begin
         case (mode)
            // R20: edge select
            TOFD_MODE_EVENT: inc = edge_sel ? fall : rise;
            // R10: internal clock
            TOFD_MODE_TIMER: inc = 1'b1;
            TOFD_MODE_PWM:
            begin
               if (!active)
               begin
                  next_active = edge_sel ? rise : fall;
               end
               else if (edge_sel ? fall : rise)
               begin
                  // R21: single shot stop
                  next_active = 1'b0;
                  en_clr = 1'b1;
               end
               else
               begin
                  inc = 1'b1;
               end
            end
            default: inc = 1'b0;
         endcase
      end
      if (!run)
      begin
         next_active = 1'b0;
      end
      // R2: count up, reload
      if (inc)
      begin
         if (&cnt)
         begin
            ovf = 1'b1;
            next_cnt = preload;
         end
         else
         begin
            next_cnt = W'(cnt + 1'b1);
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         preload <= '0;
         cnt <= '0;
         pin_q <= 1'b0;
         active <= 1'b0;
      end
      else
      begin
         preload <= next_preload;
         cnt <= next_cnt;
         pin_q <= next_pin_q;
         active <= next_active;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_reload_on_ovf: assert property (@(posedge clk) disable iff (rst) // R2
      ovf |=> cnt == $past(preload))
      else $error("counter did not reload after overflow");
   a_hold_freezes: assert property (@(posedge clk) disable iff (rst) // R12
      (cif.hold && !cif.wr_cnt) |=> cnt == $past(cnt))
      else $error("counter moved during access");
   a_timer_counts: assert property (@(posedge clk) disable iff (rst) // R10
      (mode == TOFD_MODE_TIMER && run && cif.tick && !cif.hold && !cif.wr_cnt && !(&cnt))
      |=> cnt == $past(cnt) + 1'b1)
      else $error("timer mode did not count");
endmodule : tofd_counter

/* File: tofd_top.sv */
// Top: two timer/event counters, overflow flags, wake-up and divider pin.
// Assumes a plain register port with one-cycle strobes, read data next cycle.
//
// Behaviour
// R1: divider output toggles on each overflow of selected timer.
// R2: counter counts up from preload, overflows, reloads, keeps counting.
// R3: option parameter enables divider and picks its timer; else plain pin.
// R4: divider reaches pin only when port D direction bit 0 is output.
// R5: port D data bit gates divider; zero forces pin low.
// R6: three-bit prescale field selects division of internal clock.
// R7: both overflows feed divider choice and their interrupts.
// R8: software selects pin mode and sets port B bit 7 as input.
// R9: optional pull-high stays active while pin is a timer input.
// R10: timer mode counts system clock; overflow raises interrupt.
// R11: pin events act only on the next timer clock tick.
// R12: counter clock held during register read or write.
// R13: interrupt stays inactive unless its enable bit is set.
// R14: software loads counter before turning timer on.
// R15: software sets enable after mode, in a separate write.
// R16: overflow sets request flag; interrupt only when enabled.
// R17: overflow in power-down wakes device regardless of enable.
// R18: no overflow wake-up while the request flag is already set.
// R19: bit 4 starts timer when set, stops when cleared.
// R20: bit 3 selects counted edge or measured level.
// R21: pulse width mode clears enable when pin returns.
// R22: divider toggle state resets low.
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ns
module tofd_top
   import tofd_pkg::*;
#(
   parameter bit PFD_ON = 1'b1,
   parameter bit PFD_SRC = 1'b0,
   parameter bit PULL_HIGH = 1'b1
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic shared_timer_input_pin,
   output logic shared_timer_pull_en,
   input wire logic divider_pin_in,
   output logic divider_pin_out,
   output logic divider_pin_oe,
   output logic timer0_irq,
   output logic timer1_irq,
   output logic wake
);
   tofd_cnt_if c0 ();
   tofd_cnt_if c1 ();

   logic [7:0] timer0_control_reg;
   logic [7:0] timer1_control_reg;
   logic [7:0] intc;
   logic [7:0] port;
   logic [7:0] t1_lo_buf;
   logic [6:0] psc;
   logic freq_divider_output;
   logic [7:0] next_t0c;
   logic [7:0] next_t1c;
   logic [7:0] next_intc;
   logic [7:0] next_port;
   logic [7:0] next_t1_lo_buf;
   logic [6:0] next_psc;
   logic next_fdo;
   logic [7:0] next_rdata;
   logic next_pin_out;
   logic next_pin_oe;
   logic next_irq0;
   logic next_irq1;
   logic next_wake;
   logic next_pull;
   logic [6:0] psc_plus;
   logic sel_ovf;
   logic port_d_direction_reg;
   logic divider_pin_data_bit;
   logic port_b_direction_reg;
   logic access;

   assign psc_plus = 7'(psc + 1'b1);
   assign port_d_direction_reg = port[TOFD_PORT_PDDIR];
   assign divider_pin_data_bit = port[TOFD_PORT_PDDAT];
   assign port_b_direction_reg = port[TOFD_PORT_PBDIR];
   assign access = wr | rd;

   // ----------------------------------------
   // Prescaler taps
   // ----------------------------------------
   // Rising edge of free counter bit n-1 gives one tick per 2^n cycles
   function automatic logic tap(input logic [2:0] sel, input logic [6:0] p, input logic [6:0] pn);
      logic r;
      r = 1'b1;
      if (sel != 3'h0)
      begin
         r = p[sel - 3'h1] & ~pn[sel - 3'h1];
      end
      return r;
   endfunction : tap

   always_comb
   begin
      c0.ctl = timer0_control_reg;
      c1.ctl = timer1_control_reg;
      c0.wr_cnt = wr && addr == TOFD_ADDR_T0CNT;
      c0.wr_val = {8'h00, wdata};
      // High byte write commits the buffered low byte
      c1.wr_cnt = wr && addr == TOFD_ADDR_T1CNTH;
      c1.wr_val = {wdata, t1_lo_buf};
      // R12: any access holds clock
      // Counts are lost while stalled; software must allow for it
      c0.hold = access;
      c1.hold = access;
      // R6: prescale tick
      c0.tick = timer0_control_reg[TOFD_MODE_HI:TOFD_MODE_LO] == TOFD_MODE_EVENT ? 1'b1
         : tap(timer0_control_reg[TOFD_PSC_HI:TOFD_PSC_LO], psc_plus, psc);
      c1.tick = timer1_control_reg[TOFD_MODE_HI:TOFD_MODE_LO] == TOFD_MODE_EVENT ? 1'b1
         : tap(timer1_control_reg[TOFD_PSC_HI:TOFD_PSC_LO], psc_plus, psc);
      c0.pin = shared_timer_input_pin;
      c1.pin = shared_timer_input_pin;
   end

   // ----------------------------------------
   // Counters
   // ----------------------------------------
   tofd_counter #(.W(8)) u_t0 (
      .clk(clk),
      .rst(rst),
      .cif(c0)
   );
   tofd_counter #(.W(16)) u_t1 (
      .clk(clk),
      .rst(rst),
      .cif(c1)
   );

   // R7: either overflow may feed divider
   assign sel_ovf = PFD_SRC ? c1.ovf : c0.ovf;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      next_t0c = timer0_control_reg;
      next_t1c = timer1_control_reg;
      next_intc = intc;
      next_port = port;
      next_t1_lo_buf = t1_lo_buf;
      next_psc = psc_plus;
      next_fdo = freq_divider_output;
      next_rdata = 8'h00;
      // R21: auto clear of enable
      if (c0.en_clr)
      begin
         next_t0c[TOFD_EN_BIT] = 1'b0;
      end
      if (c1.en_clr)
      begin
         next_t1c[TOFD_EN_BIT] = 1'b0;
      end
      // R19: enable bit written by software
      if (wr)
      begin
         case (addr)
            TOFD_ADDR_T0CTL: next_t0c = wdata;
            TOFD_ADDR_T1CTL: next_t1c = wdata;
            TOFD_ADDR_T1CNTL: next_t1_lo_buf = wdata;
            TOFD_ADDR_INTC: next_intc = wdata;
            TOFD_ADDR_PORT: next_port = wdata;
            default: next_t1_lo_buf = t1_lo_buf;
         endcase
      end
      // R16: overflow sets flag, set wins
      if (c0.ovf)
      begin
         next_intc[TOFD_INTC_T0F] = 1'b1;
      end
      if (c1.ovf)
      begin
         next_intc[TOFD_INTC_T1F] = 1'b1;
      end
      // R1: toggle on selected overflow
      if (PFD_ON && sel_ovf)
      begin
         next_fdo = ~freq_divider_output;
      end
      if (rd)
      begin
         case (addr)
            TOFD_ADDR_T0CTL: next_rdata = timer0_control_reg;
            TOFD_ADDR_T0CNT: next_rdata = c0.cnt[7:0];
            TOFD_ADDR_T1CTL: next_rdata = timer1_control_reg;
            TOFD_ADDR_T1CNTL: next_rdata = c1.cnt[7:0];
            TOFD_ADDR_T1CNTH: next_rdata = c1.cnt[15:8];
            TOFD_ADDR_INTC: next_rdata = intc;
            TOFD_ADDR_PORT: next_rdata = port;
            TOFD_ADDR_STAT: next_rdata = {6'h00, c1.ovf, freq_divider_output};
            default: next_rdata = 8'h00;
         endcase
      end
      // R3: divider only when option selected
      if (PFD_ON)
      begin
         // R4: output only when direction is output
         // R5: data bit gates the toggle
         next_pin_out = divider_pin_data_bit & next_fdo;
      end
      else
      begin
         next_pin_out = port[TOFD_PORT_PDOUT];
      end
      next_pin_oe = ~port_d_direction_reg;
      // R13: gated by enable bits
      next_irq0 = next_intc[TOFD_INTC_T0F] & next_intc[TOFD_INTC_T0EN];
      next_irq1 = next_intc[TOFD_INTC_T1F] & next_intc[TOFD_INTC_T1EN];
      // R17: wake regardless of enable
      // R18: blocked if flag already set
      // Old flag, so the overflow that sets it still wakes once
      next_wake = port[TOFD_PORT_PDN]
         & ((c0.ovf & ~intc[TOFD_INTC_T0F]) | (c1.ovf & ~intc[TOFD_INTC_T1F]));
      // R9: pull-high kept on input
      next_pull = PULL_HIGH & port_b_direction_reg;
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         timer0_control_reg <= TOFD_RST_CTL;
         timer1_control_reg <= TOFD_RST_CTL;
         intc <= TOFD_RST_INTC;
         port <= TOFD_RST_PORT;
         t1_lo_buf <= 8'h00;
         psc <= TOFD_RST_PSC;
         // R22: divider resets low
         freq_divider_output <= 1'b0;
         rdata <= 8'h00;
         divider_pin_out <= 1'b0;
         divider_pin_oe <= 1'b0;
         timer0_irq <= 1'b0;
         timer1_irq <= 1'b0;
         wake <= 1'b0;
         shared_timer_pull_en <= 1'b0;
      end
      else
      begin
         timer0_control_reg <= next_t0c;
         timer1_control_reg <= next_t1c;
         intc <= next_intc;
         port <= next_port;
         t1_lo_buf <= next_t1_lo_buf;
         psc <= next_psc;
         freq_divider_output <= next_fdo;
         rdata <= next_rdata;
         divider_pin_out <= next_pin_out;
         divider_pin_oe <= next_pin_oe;
         timer0_irq <= next_irq0;
         timer1_irq <= next_irq1;
         wake <= next_wake;
         shared_timer_pull_en <= next_pull;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_div_toggles: assert property (@(posedge clk) disable iff (rst) // R1
      (PFD_ON && sel_ovf) |=> freq_divider_output != $past(freq_divider_output))
      else $error("divider did not toggle on overflow");

   a_div_reset_low: assert property (@(posedge clk) disable iff (rst) // R22
      $fell(rst) |-> !freq_divider_output)
      else $error("divider not low after reset");

   a_pin_gated_low: assert property (@(posedge clk) disable iff (rst) // R5
      (PFD_ON && !divider_pin_data_bit && !wr) |=> !divider_pin_out)
      else $error("divider pin not forced low");

   a_pin_follows: assert property (@(posedge clk) disable iff (rst) // R5
      (PFD_ON && divider_pin_data_bit && !wr) |=> divider_pin_out == freq_divider_output)
      else $error("divider pin does not follow toggle");

   a_flag_set: assert property (@(posedge clk) disable iff (rst) // R16
      c0.ovf |=> intc[TOFD_INTC_T0F])
      else $error("overflow flag not set");

   a_t1_flag_set: assert property (@(posedge clk) disable iff (rst) // R7
      c1.ovf |=> intc[TOFD_INTC_T1F])
      else $error("timer 1 overflow flag not set");

   a_irq_follows: assert property (@(posedge clk) disable iff (rst) // R16
      (c0.ovf && intc[TOFD_INTC_T0EN] && !wr) |=> timer0_irq)
      else $error("enabled overflow gave no interrupt");

   a_irq_masked: assert property (@(posedge clk) disable iff (rst) // R13
      !intc[TOFD_INTC_T0EN] |-> !timer0_irq)
      else $error("interrupt active while disabled");

   a_irq1_masked: assert property (@(posedge clk) disable iff (rst) // R13
      !intc[TOFD_INTC_T1EN] |-> !timer1_irq)
      else $error("timer 1 interrupt active while disabled");

   a_wake_blocked: assert property (@(posedge clk) disable iff (rst) // R18
      (intc[TOFD_INTC_T0F] && intc[TOFD_INTC_T1F]) |=> !wake)
      else $error("wake-up while flags set");

   a_wake_pdn: assert property (@(posedge clk) disable iff (rst) // R17
      (port[TOFD_PORT_PDN] && c1.ovf && !intc[TOFD_INTC_T1F]) |=> wake)
      else $error("no wake-up on overflow in power-down");

   a_wake_pdn0: assert property (@(posedge clk) disable iff (rst) // R17
      (port[TOFD_PORT_PDN] && c0.ovf && !intc[TOFD_INTC_T0F]) |=> wake)
      else $error("no wake-up on timer 0 overflow in power-down");

   a_pwm_clear: assert property (@(posedge clk) disable iff (rst) // R21
      (c0.en_clr && !wr) |=> !timer0_control_reg[TOFD_EN_BIT])
      else $error("enable not cleared after pulse");

   a_oe_dir: assert property (@(posedge clk) disable iff (rst) // R4
      port_d_direction_reg && !wr |=> !divider_pin_oe)
      else $error("pin driven while input");

   a_oe_output: assert property (@(posedge clk) disable iff (rst) // R4
      (!port_d_direction_reg && !wr) |=> divider_pin_oe)
      else $error("pin not driven while output");

   a_pull_input: assert property (@(posedge clk) disable iff (rst) // R9
      port_b_direction_reg |=> shared_timer_pull_en == PULL_HIGH)
      else $error("pull-high lost while pin is input");

   a_access_stall: assert property (@(posedge clk) disable iff (rst) // R12
      access |-> !c0.ovf && !c1.ovf)
      else $error("counter overflowed during access");

   a_stop_no_ovf: assert property (@(posedge clk) disable iff (rst) // R19
      !timer0_control_reg[TOFD_EN_BIT] |-> !c0.ovf)
      else $error("stopped timer overflowed");

   // ----------------------------------------
   // Coverage
   // ----------------------------------------
   c_div_toggle: cover property (@(posedge clk) disable iff (rst) sel_ovf ##1 divider_pin_out);
   c_wake: cover property (@(posedge clk) disable iff (rst) wake);
   c_pwm_stop: cover property (@(posedge clk) disable iff (rst) c0.en_clr);
   c_t1_irq: cover property (@(posedge clk) disable iff (rst) timer1_irq);
   c_event_ovf: cover property (@(posedge clk) disable iff (rst)
      timer0_control_reg[TOFD_MODE_HI:TOFD_MODE_LO] == TOFD_MODE_EVENT && c0.ovf);
endmodule : tofd_top

/* File: tofd_partner.sv */
// Partner: pulse source on the shared timer pin, load on the divider pin.
// Assumes the bench calls its tasks and reads its toggle record.
`timescale 1ns/1ns
module tofd_partner
(
   input wire logic clk,
   input wire logic pull_en,
   input wire logic div_out,
   input wire logic div_oe,
   output logic pin
);
   logic drv = 1'b0;
   logic lvl = 1'b0;
   logic seen = 1'b0;
   int cyc = 0;
   int toggles = 0;
   int t_last = 0;
   int t_prev = 0;
   // ----------------------------------------
   // Pin level
   // ----------------------------------------
   // released pin sits at pull level
   // Without pull, show the inverse so a stale value never passes
   assign pin = drv ? lvl : (pull_en ? 1'b1 : ~lvl);
   // ----------------------------------------
   // Load: toggle record
   // ----------------------------------------
   // count divider changes while driven
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (div_oe === 1'b1 && div_out !== seen)
      begin
         seen <= div_out;
         toggles <= toggles + 1;
         t_prev <= t_last;
         t_last <= cyc;
      end
   end
   // pin moves just after an edge
   task automatic level(input logic v);
      @(posedge clk);
      lvl <= v;
      drv <= 1'b1;
      repeat (3) @(posedge clk);
   endtask : level
   // n pulses away from idle, each width cycles, then width cycles back at idle
   task automatic pulses(input int n, input logic idle, input int width);
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk);
         lvl <= ~idle;
         repeat (width) @(posedge clk);
         lvl <= idle;
         repeat (width) @(posedge clk);
      end
   endtask : pulses
endmodule : tofd_partner

/* File: tofd_top_tb.sv */
// Testbench: timer overflow, divider pin, flags and wake-up.
// Assumes the design top and package compiled before it.
`timescale 1ns/1ns
module tofd_top_tb
   import tofd_pkg::*;
;
   typedef struct {logic [7:0] pre; logic [2:0] psc; int k; int gap;} tofd_row_t;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic tpin, pull_en, dout, doe, din, irq0, irq1, wake, hi;
   logic [7:0] rv, rv2;
   int bad_count = 0;
   int samples_checked = 0;
   int wakes = 0;
   int gap, n, i;
   // Stall rows use prescale 0 so each lost tick is one cycle
   tofd_row_t rows [6] = '{'{8'h9B, 3'h1, 0, 202}, '{8'hF0, 3'h0, 0, 16}, '{8'hF0, 3'h0, 5, 21},
      '{8'hFE, 3'h2, 0, 8}, '{8'h00, 3'h0, 0, 256}, '{8'hFF, 3'h7, 0, 128}};
   always #20 clk = ~clk;
   assign din = doe ? dout : ~dout;
   always @(posedge clk) if (wake === 1'b1) wakes <= wakes + 1;
   tofd_top tofd_top_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .shared_timer_input_pin(tpin), .shared_timer_pull_en(pull_en),
      .divider_pin_in(din), .divider_pin_out(dout), .divider_pin_oe(doe),
      .timer0_irq(irq0), .timer1_irq(irq1), .wake(wake));
   tofd_partner tofd_partner_inst (.clk(clk), .pull_en(pull_en), .div_out(dout), .div_oe(doe), .pin(tpin));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : check
   task automatic test_done;
      $display("checks %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : test_done
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rreg
   task automatic wait_tog(input int t);
      for (int j = 0; j < 3000 && tofd_partner_inst.toggles < t; j++)
      begin
         @(posedge clk);
         #1;
      end
      check(16'(tofd_partner_inst.toggles >= t), 16'h0001);
   endtask : wait_tog
   task automatic measure(input int k, output int g);
      int n0;
      n0 = tofd_partner_inst.toggles;
      wait_tog(n0 + 1);
      for (int j = 0; j < k; j++)
      begin
         @(posedge clk);
         addr <= TOFD_ADDR_STAT;
         rd <= 1'b1;
      end
      @(posedge clk);
      rd <= 1'b0;
      wait_tog(n0 + 2);
      g = tofd_partner_inst.t_last - tofd_partner_inst.t_prev;
   endtask : measure
   initial
   begin
      #(40 * 30000);
      bad_count++;
      test_done();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1 check({rdata, pull_en, dout, doe, irq0, irq1, wake}, 16'h0000);
      rreg(TOFD_ADDR_INTC, rv);
      check(rv, TOFD_RST_INTC);
      rreg(TOFD_ADDR_PORT, rv);
      check(rv, TOFD_RST_PORT);
      rreg(TOFD_ADDR_T0CTL, rv);
      check(rv, TOFD_RST_CTL);
      wreg(4'hF, 8'hFF);
      rreg(4'hF, rv);
      check(rv, 8'h00);
      wreg(TOFD_ADDR_PORT, 8'h02);
      foreach (rows[r])
      begin
         wreg(TOFD_ADDR_T0CTL, 8'h00);
         wreg(TOFD_ADDR_T0CNT, rows[r].pre);
         wreg(TOFD_ADDR_T0CTL, {TOFD_MODE_TIMER, 3'h0, rows[r].psc});
         wreg(TOFD_ADDR_T0CTL, {TOFD_MODE_TIMER, 3'h2, rows[r].psc});
         measure(rows[r].k, gap);
         check(16'(gap), 16'(rows[r].gap));
         rreg(TOFD_ADDR_INTC, rv);
         check(rv[TOFD_INTC_T0F], 1'b1);
         check(irq0, 1'b0);
      end
      // Data bit low holds pin low while the timer runs
      wreg(TOFD_ADDR_PORT, 8'h00);
      hi = 1'b0;
      repeat (300)
      begin
         @(posedge clk);
         #1 hi = hi | dout;
      end
      check(hi, 1'b0);
      check(doe, 1'b1);
      wreg(TOFD_ADDR_PORT, 8'h03);
      @(posedge clk);
      #1 check(doe, 1'b0);
      wreg(TOFD_ADDR_PORT, 8'h02);
      wreg(TOFD_ADDR_INTC, 8'h02);
      for (i = 0; i < 300 && irq0 !== 1'b1; i++) @(posedge clk) #1;
      check(irq0, 1'b1);
      // Park timer 0 so no overflow refills a flag before power-down
      wreg(TOFD_ADDR_T0CTL, 8'h87);
      wreg(TOFD_ADDR_INTC, 8'h00);
      @(posedge clk);
      #1 check(irq0, 1'b0);
      // Power-down wake, then blocked by a set flag
      wreg(TOFD_ADDR_PORT, 8'h12);
      n = wakes;
      wreg(TOFD_ADDR_T0CTL, 8'h97);
      for (i = 0; i < 300 && wakes == n; i++) @(posedge clk) #1;
      check(16'(wakes > n), 16'h0001);
      wreg(TOFD_ADDR_INTC, 8'h60);
      n = wakes;
      repeat (400) @(posedge clk);
      check(16'(wakes), 16'(n));
      wreg(TOFD_ADDR_PORT, 8'h02);
      wreg(TOFD_ADDR_T0CTL, 8'h80);
      @(posedge clk);
      n = tofd_partner_inst.toggles;
      repeat (600) @(posedge clk);
      check(16'(tofd_partner_inst.toggles), 16'(n));
      // Timer 1 sixteen-bit load and its interrupt
      wreg(TOFD_ADDR_T1CNTL, 8'hF0);
      wreg(TOFD_ADDR_T1CNTH, 8'hFF);
      wreg(TOFD_ADDR_T1CTL, 8'h80);
      wreg(TOFD_ADDR_T1CTL, 8'h90);
      wreg(TOFD_ADDR_INTC, 8'h04);
      for (i = 0; i < 300 && irq1 !== 1'b1; i++) @(posedge clk) #1;
      check(irq1, 1'b1);
      wreg(TOFD_ADDR_T1CTL, 8'h00);
      // pin set as input for event counting
      wreg(TOFD_ADDR_PORT, 8'h06);
      @(posedge clk);
      #1 check(pull_en, 1'b1);
      tofd_partner_inst.level(1'b0);
      for (int e = 0; e < 2; e++)
      begin
         wreg(TOFD_ADDR_T0CTL, 8'h00);
         wreg(TOFD_ADDR_T0CNT, 8'hFC);
         wreg(TOFD_ADDR_T0CTL, {TOFD_MODE_EVENT, 2'h0, e[0], 3'h0});
         wreg(TOFD_ADDR_T0CTL, {TOFD_MODE_EVENT, 2'h1, e[0], 3'h0});
         n = tofd_partner_inst.toggles;
         tofd_partner_inst.pulses(3, 1'b0, 3);
         check(16'(tofd_partner_inst.toggles - n), 16'h0000);
         tofd_partner_inst.pulses(1, 1'b0, 3);
         check(16'(tofd_partner_inst.toggles - n), 16'h0001);
      end
      // Single-shot low pulse of 20 cycles
      tofd_partner_inst.level(1'b1);
      wreg(TOFD_ADDR_T0CTL, 8'h00);
      wreg(TOFD_ADDR_T0CNT, 8'h00);
      wreg(TOFD_ADDR_T0CTL, 8'hC0);
      wreg(TOFD_ADDR_T0CTL, 8'hD0);
      tofd_partner_inst.pulses(1, 1'b1, 20);
      rreg(TOFD_ADDR_T0CTL, rv);
      check(rv[TOFD_EN_BIT], 1'b0);
      rreg(TOFD_ADDR_T0CNT, rv);
      check(16'(rv >= 8'h12 && rv <= 8'h16), 16'h0001);
      tofd_partner_inst.pulses(1, 1'b1, 5);
      rreg(TOFD_ADDR_T0CNT, rv2);
      check(rv2, rv);
      test_done();
   end
endmodule : tofd_top_tb
